// >>> ckl_pkg.sv
// Package of constants and types for the key lifecycle controller
package ckl_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] OFF_ENABLE = 12'h500;
	localparam logic [11:0] OFF_LIFECYCLE = 12'h400;
	localparam logic [11:0] OFF_KEY_SELECT = 12'h404;
	localparam logic [11:0] OFF_FIXED_LOCK = 12'h408;
	localparam logic [11:0] OFF_ROOT_KEY0 = 12'h40c;
	localparam logic [11:0] OFF_ROOT_KEY3 = 12'h418;
	localparam logic [11:0] OFF_OP_STATUS = 12'h41c;
	localparam logic [11:0] OFF_IDLE_STATUS = 12'h420;

	// ----------------------------------------
	// Field positions and encodings
	// ----------------------------------------
	localparam int LC_FIELD_LSB = 0;
	localparam int LC_VALID_BIT = 8;
	localparam int KEY_BITS = 128;
	localparam logic [3:0] LC_DEBUG = 4'h0;
	localparam logic [3:0] LC_SECURE = 4'h2;
	localparam logic [1:0] KSEL_FIXED = 2'h0;
	localparam logic [1:0] KSEL_ROOT = 2'h1;
	localparam logic [1:0] KSEL_SESSION = 2'h2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0] RST_LIFECYCLE = LC_SECURE;
	localparam logic [1:0] RST_KEY_SELECT = KSEL_FIXED;

	// Hard-wired fixed design key, arbitrary value
	localparam logic [127:0] FIXED_DESIGN_KEY =
		128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

	typedef enum logic [1:0] {
		CKL_IDLE = 2'b00,
		CKL_BUSY = 2'b01
	} ckl_op_state_t;

	// Always-on retained state
	typedef struct packed {
		logic [3:0] lifecycle_state;
		logic lifecycle_valid_flag;
		logic fixed_key_avail;
		logic root_key_written;
		logic [127:0] device_root_key;
	} ckl_retained_t;

endpackage

// >>> ckl_key_mux.sv
// Key multiplexer holding the selected key over each operation
`timescale 1ns/1ps
module ckl_key_mux (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] key_sel,
	input wire logic fixed_avail,
	input wire logic [127:0] root_key,
	input wire logic [127:0] session_key,
	input wire logic op_start,
	input wire logic op_done,
	output logic [127:0] engine_key,
	output logic op_busy
);

	ckl_pkg::ckl_op_state_t state_q, state_d;
	logic [127:0] key_q, key_d;

	// ----------------------------------------
	// Selection
	// ----------------------------------------
	function automatic logic [127:0] pick(input logic [1:0] s,
		input logic avail, input logic [127:0] rk,
		input logic [127:0] sk);
		case (s)
			ckl_pkg::KSEL_FIXED: pick = avail ?
				ckl_pkg::FIXED_DESIGN_KEY : '0;
			ckl_pkg::KSEL_ROOT: pick = rk;
			ckl_pkg::KSEL_SESSION: pick = sk;
			default: pick = '0;
		endcase
	endfunction

	always_comb begin
		state_d = state_q;
		key_d = key_q;
		case (state_q)
			ckl_pkg::CKL_IDLE: begin
				if (op_start) begin
					key_d = pick(key_sel, fixed_avail, root_key,
						session_key);
					state_d = ckl_pkg::CKL_BUSY;
				end
			end
			ckl_pkg::CKL_BUSY: begin
				if (op_done) begin
					state_d = ckl_pkg::CKL_IDLE;
				end
			end
			default: state_d = ckl_pkg::CKL_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ckl_pkg::CKL_IDLE;
			key_q <= '0;
		end else begin
			state_q <= state_d;
			key_q <= key_d;
		end
	end

	assign engine_key = key_q;
	assign op_busy = (state_q == ckl_pkg::CKL_BUSY);

endmodule

// >>> ckl_ctrl.sv
// AHB-Lite controlled key lifecycle controller
// Behaviour
// - Enabled subsystem blocks the all-idle state; disabling permits it.
// - Always-on domain keeps lifecycle, fixed-key flag and root key.
// - Any reset clears all retained state.
// - Validity flag goes valid once a valid encoding is written.
// - After reset lifecycle reads secure and validity invalid.
// - Valid secure state accepts one root key write per reset.
// - Valid debug state accepts repeated root key writes.
// - Key-select chooses fixed, root or session key.
// - Fixed key is hard-wired and never readable by software.
// - Writing the lock register blocks fixed key until reset.
// - Locked fixed key selected routes all-zero key to engine.
// - Root key words are write-only; reads never return key.
// - First root key word reads 1 once key is retained.
// - Selected root key is used internally, never exposed.
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ckl_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [127:0] session_key,
	input wire logic op_start,
	input wire logic op_done,
	output logic [127:0] engine_key,
	output logic op_busy,
	output logic subsys_enabled,
	output logic all_idle_allowed
);

	// ----------------------------------------
	// Bus address phase capture
	// ----------------------------------------
	logic wr_pend_q, wr_pend_d;
	logic [11:0] addr_q, addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic addr_valid;

	assign addr_valid = hsel && hready && htrans[1];

	always_comb begin
		wr_pend_d = addr_valid && hwrite;
		addr_d = addr_valid ? haddr[11:0] : addr_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= '0;
		end else begin
			wr_pend_q <= wr_pend_d;
			addr_q <= addr_d;
		end
	end

	// ----------------------------------------
	// Retained and control state
	// ----------------------------------------
	ckl_pkg::ckl_retained_t ret_q, ret_d;
	logic enable_q, enable_d;
	logic [1:0] ksel_q, ksel_d;
	logic [1:0] widx;
	logic key_wr_ok;

	function automatic logic lc_is_valid_code(input logic [3:0] v);
		lc_is_valid_code = (v == ckl_pkg::LC_DEBUG) ||
			(v == ckl_pkg::LC_SECURE);
	endfunction

	assign widx = addr_q[3:2] - 2'(ckl_pkg::OFF_ROOT_KEY0 >> 2);

	// Debug: repeated writes; secure: once per reset
	always_comb begin
		key_wr_ok = 1'b0;
		if (ret_q.lifecycle_valid_flag) begin
			if (ret_q.lifecycle_state == ckl_pkg::LC_DEBUG) begin
				key_wr_ok = 1'b1;
			end else begin
				key_wr_ok = !ret_q.root_key_written;
			end
		end
	end

	always_comb begin
		ret_d = ret_q;
		enable_d = enable_q;
		ksel_d = ksel_q;
		if (wr_pend_q) begin
			case (addr_q)
				ckl_pkg::OFF_ENABLE: enable_d = hwdata[0];
				ckl_pkg::OFF_LIFECYCLE: begin
					if (lc_is_valid_code(hwdata[3:0])) begin
						ret_d.lifecycle_state = hwdata[3:0];
						ret_d.lifecycle_valid_flag = 1'b1;
					end
				end
				ckl_pkg::OFF_KEY_SELECT: ksel_d = hwdata[1:0];
				ckl_pkg::OFF_FIXED_LOCK: ret_d.fixed_key_avail = 1'b0;
				default: begin
					if (addr_q >= ckl_pkg::OFF_ROOT_KEY0 &&
						addr_q <= ckl_pkg::OFF_ROOT_KEY3 &&
						key_wr_ok) begin
						ret_d.device_root_key[32*widx +: 32] = hwdata;
						if (widx == 2'd3) begin
							ret_d.root_key_written = 1'b1;
						end
					end
				end
			endcase
		end
	end

	// Retention domain cleared by any reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ret_q.lifecycle_state <= ckl_pkg::RST_LIFECYCLE;
			ret_q.lifecycle_valid_flag <= 1'b0;
			ret_q.fixed_key_avail <= 1'b1;
			ret_q.root_key_written <= 1'b0;
			ret_q.device_root_key <= '0;
			enable_q <= 1'b0;
			ksel_q <= ckl_pkg::RST_KEY_SELECT;
		end else begin
			ret_q <= ret_d;
			enable_q <= enable_d;
			ksel_q <= ksel_d;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		rdata_d = '0;
		if (addr_valid && !hwrite) begin
			case (haddr[11:0])
				ckl_pkg::OFF_ENABLE: rdata_d = {31'h0, enable_q};
				ckl_pkg::OFF_LIFECYCLE: begin
					rdata_d[ckl_pkg::LC_FIELD_LSB +: 4] = ret_q.lifecycle_state;
					rdata_d[ckl_pkg::LC_VALID_BIT] = ret_q.lifecycle_valid_flag;
				end
				ckl_pkg::OFF_KEY_SELECT: rdata_d = {30'h0, ksel_q};
				ckl_pkg::OFF_FIXED_LOCK:
					rdata_d = {31'h0, !ret_q.fixed_key_avail};
				ckl_pkg::OFF_ROOT_KEY0:
					rdata_d = {31'h0, ret_q.root_key_written};
				ckl_pkg::OFF_OP_STATUS: rdata_d = {31'h0, op_busy};
				ckl_pkg::OFF_IDLE_STATUS: rdata_d = {31'h0, all_idle_allowed};
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------
	// Power and key path
	// ----------------------------------------
	assign subsys_enabled = enable_q;
	assign all_idle_allowed = !enable_q;

	ckl_key_mux u_mux (
		.hclk(hclk),
		.hresetn(hresetn),
		.key_sel(ksel_q),
		.fixed_avail(ret_q.fixed_key_avail),
		.root_key(ret_q.device_root_key),
		.session_key(session_key),
		.op_start(op_start && enable_q),
		.op_done(op_done),
		.engine_key(engine_key),
		.op_busy(op_busy)
	);

endmodule

// >>> ckl_ctrl_asserts.sv
// Port checks for the key lifecycle controller
`timescale 1ns/1ps
module ckl_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic op_start,
	input wire logic op_done,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [127:0] engine_key,
	input wire logic op_busy,
	input wire logic subsys_enabled,
	input wire logic all_idle_allowed
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_start;
		!op_busy && op_start && subsys_enabled;
	endsequence
	sequence s_held;
		op_busy ##1 op_busy;
	endsequence
	a_idle_gate: assert property (
		all_idle_allowed == !subsys_enabled) else $error("idle gate");
	a_reset_clear: assert property (
		$rose(hresetn) |-> !op_busy && engine_key == 128'h0)
		else $error("reset clear");
	a_busy_start: assert property (
		s_start |=> op_busy) else $error("busy start");
	a_busy_cause: assert property (
		$rose(op_busy) |-> $past(op_start)) else $error("busy cause");
	a_busy_end: assert property (
		op_busy && op_done |=> !op_busy) else $error("busy end");
	a_key_hold: assert property (
		s_held |-> $stable(engine_key)) else $error("key hold");
	a_fixed_hidden: assert property (
		hrdata != ckl_pkg::FIXED_DESIGN_KEY[31:0]) else $error("fixed");
	a_root_hidden: assert property (
		engine_key != 128'h0 |-> hrdata != engine_key[31:0])
		else $error("key seen");
	a_bus_okay: assert property (
		hreadyout && !hresp) else $error("bus resp");
endmodule
bind ckl_ctrl ckl_chk u_chk (.hclk, .hresetn, .op_start, .op_done,
	.hrdata, .hreadyout, .hresp, .engine_key, .op_busy,
	.subsys_enabled, .all_idle_allowed);

// >>> testbench.sv
// Testbench for the key lifecycle controller
`timescale 1ns/1ps
module testbench;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [127:0] session_key, engine_key;
	logic op_start, op_done, op_busy, subsys_enabled, all_idle_allowed;
	int mismatches = 0;
	int n_tests = 0;
	localparam logic [11:0] LC = ckl_pkg::OFF_LIFECYCLE;
	localparam logic [11:0] KS = ckl_pkg::OFF_KEY_SELECT;
	localparam logic [11:0] LK = ckl_pkg::OFF_FIXED_LOCK;
	localparam logic [11:0] R0 = ckl_pkg::OFF_ROOT_KEY0;
	localparam logic [11:0] EN = ckl_pkg::OFF_ENABLE;
	localparam logic [31:0] SEC = 32'(ckl_pkg::LC_SECURE);
	localparam logic [31:0] DBG = 32'(ckl_pkg::LC_DEBUG);
	localparam logic [31:0] VLD = 32'h1 << ckl_pkg::LC_VALID_BIT;
	localparam logic [127:0] K1 = 128'hc0de_0004_c0de_0003_c0de_0002_c0de_0001;
	localparam logic [127:0] K2 = 128'h9e37_79b9_7f4a_7c15_f39c_c060_5ced_c834;
	assign hready = hreadyout;
	ckl_ctrl u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.session_key, .op_start, .op_done, .engine_key, .op_busy,
		.subsys_enabled, .all_idle_allowed);
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	task automatic summarize;
		if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wait_rdy(inout int n);
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			chk(hready, 1'b1);
			summarize();
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy(n);
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy(n);
		r = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	task automatic ld(input logic [127:0] k);
		for (int i = 0; i < 4; i++) wr(R0 + 12'(4 * i), k[32 * i +: 32]);
	endtask
	task automatic op(input logic [1:0] s, input logic [127:0] e);
		int n;
		n = 0;
		wr(KS, 32'(s));
		op_start <= 1'b1;
		@(posedge hclk);
		op_start <= 1'b0;
		do begin
			@(posedge hclk);
			n++;
		end while (op_busy !== 1'b1 && n < 20);
		if (op_busy !== 1'b1) begin
			chk(op_busy, 1'b1);
			summarize();
		end
		chk(engine_key, e);
		rc(ckl_pkg::OFF_OP_STATUS, 32'h1);
		session_key <= ~session_key;
		wr(KS, 32'(s ^ 2'h1));
		op_done <= 1'b1;
		@(posedge hclk);
		op_done <= 1'b0;
		chk(engine_key, e);
		@(posedge hclk);
		chk(op_busy, 1'b0);
	endtask
	task automatic t_sec;
		rc(LC, SEC);
		rc(R0, 32'h0);
		wr(EN, 32'h1);
		@(posedge hclk);
		chk(all_idle_allowed, 1'b0);
		chk(subsys_enabled, 1'b1);
		rc(ckl_pkg::OFF_IDLE_STATUS, 32'h0);
		wr(LC, 32'h5);
		rc(LC, SEC);
		wr(LC, SEC);
		rc(LC, SEC | VLD);
		ld(K1);
		rc(R0, 32'h1);
		rc(R0 + 12'h4, 32'h0);
		ld(K2);
		op(ckl_pkg::KSEL_ROOT, K1);
	endtask
	task automatic t_key;
		op(ckl_pkg::KSEL_FIXED, ckl_pkg::FIXED_DESIGN_KEY);
		wr(LK, 32'h0);
		rc(LK, 32'h1);
		op(ckl_pkg::KSEL_FIXED, 128'h0);
		op(ckl_pkg::KSEL_SESSION, session_key);
	endtask
	task automatic t_dbg;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(engine_key, 128'h0);
		rc(LC, SEC);
		rc(LK, 32'h0);
		rc(R0, 32'h0);
		wr(EN, 32'h1);
		op(ckl_pkg::KSEL_ROOT, 128'h0);
		wr(LC, DBG);
		rc(LC, DBG | VLD);
		ld(K1);
		ld(K2);
		rc(R0, 32'h1);
		rc(R0 + 12'h8, 32'h0);
		op(ckl_pkg::KSEL_ROOT, K2);
		wr(EN, 32'h0);
		@(posedge hclk);
		chk(all_idle_allowed, 1'b1);
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		session_key = {4{32'h5a5a_c3c3}};
		op_start = 1'b0;
		op_done = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_sec();
		t_key();
		t_dbg();
		summarize();
	end
endmodule
